// file: verilog/uic_pkg.sv
// shared constants and types for the uart interrupt and fifo control block
package uic_pkg;
    localparam logic [2:0] OFS_DATA   = 3'h0;
    localparam logic [2:0] OFS_IE     = 3'h1;
    localparam logic [2:0] OFS_ISFC   = 3'h2;
    localparam logic [2:0] OFS_LCR    = 3'h3;
    localparam logic [2:0] OFS_LSR    = 3'h5;
    localparam logic [2:0] OFS_MSR    = 3'h6;
    localparam logic [3:0] OFS_EFR_LO = 4'h8;
    localparam logic [7:0] LCR_ENH    = 8'hbf;
    localparam int         LCR_DLAB   = 7;
    localparam int         EFR_ENH    = 4;
    localparam int         EFR_ARTS   = 6;
    localparam int         EFR_ACTS   = 7;
    localparam int         FC_EN      = 0;
    localparam int         FC_RXRST   = 1;
    localparam int         FC_TXRST   = 2;
    localparam logic [7:0] IE_RST     = 8'h00;
    localparam logic [7:0] LCR_RST    = 8'h00;
    localparam logic [5:0] CODE_LS    = 6'h06;
    localparam logic [5:0] CODE_TO    = 6'h0c;
    localparam logic [5:0] CODE_RX    = 6'h04;
    localparam logic [5:0] CODE_TX    = 6'h02;
    localparam logic [5:0] CODE_MS    = 6'h00;
    localparam logic [5:0] CODE_XOFF  = 6'h10;
    localparam logic [5:0] CODE_FLOW  = 6'h20;
    localparam logic [5:0] CODE_NONE  = 6'h01;
    localparam int         TO_CHARS   = 4;
    localparam int         TO_BITS    = 12;
    localparam int         BAUD_OVS   = 16;
    typedef struct packed {
        logic       rx_push;
        logic       rx_pop_err;
        logic       rx_overrun;
        logic [2:0] rx_err_type;
        logic       rx_fifo_err;
        logic       xoff_det;
        logic       xon_det;
        logic       special_det;
        logic       wake;
        logic       tx_empty_hold;
        logic       tx_all_empty;
        logic       cts_pin;
        logic       rts_pin;
        logic [3:0] modem_delta;
        logic [3:0] modem_in;
    } uic_core_s;
endpackage

// file: verilog/uic_top.sv
// interrupt enable, prioritised status, line status and fifo control over ahb-lite
// Function
// R1: receive data irq: holding register full, or fifo at trigger level
// R2: transmit ready irq on holding empty or below trigger; enabling while empty fires
// R3: line status irq when any of status bits 1 to 4 set
// R4: modem status irq when any modem delta bit is set
// R5: upper four enable bits writable only with enhanced bit, reset disabled
// R6: irq on rising cts or rts while matching auto flow control active
// R7: fifo receive irq and code track trigger level exactly
// R8: data ready sets on push, clears only when receive fifo empty
// R9: line status: overrun, error type, holding empty, all empty, fifo error
// R10: timeout after four chars plus twelve bits, cleared by holding read
// R11: transmit ready cleared by status read or holding write
// R12: line status read clears irq; fifo error bit persists while errors remain
// R13: modem status read clears modem and flow irqs; the block clears only the flow irq, the modem irq follows modem_delta
// R14: xoff clears on status read or xon; special on read or next char
// R15: wake-up irq shown as no-pending code, cleared by status read
// R16: six bit code by fixed priority table
// R17: only highest pending shown; others wait until serviced
// R18: status bit 0 low while pending, high when none or wake-up
// R19: status bits 5:4 need enhanced bit; bits 7:6 mirror fifo enable
// R20: fifo enable bit gates every other fifo control bit in the write
// R21: receive fifo reset pulse clears pointers then self-clears
// R22: sixteen bit divisor reachable only with divisor select set
// R23: trigger fields pick 1, 4, 8 or 14; transmit field needs enhanced bit
// R24: transmit fifo reset pulse clears pointers then self-clears
// R25: irq output high while any enabled source pending
// R26: all four standard enables clear with fifos gives polled mode
`timescale 1ns/1ps
module uic_top #(
    parameter int DEPTH = 16,
    parameter int LW    = 5
) (
    // clock, reset, enable
    input  wire logic                CLK,
    input  wire logic                RST_N,
    input  wire logic                CE,
    // ahb-lite slave
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    // core status inputs, same clock
    input  wire uic_pkg::uic_core_s  CORE,
    input  wire logic [LW-1:0]       RX_LEVEL,
    input  wire logic [LW-1:0]       TX_LEVEL,
    input  wire logic [7:0]          RX_DATA,
    // control outputs to core
    output logic                     RX_POP,
    output logic                     TX_PUSH,
    output logic      [7:0]          TX_DATA,
    output logic                     RX_FIFO_RST,
    output logic                     TX_FIFO_RST,
    output logic                     FIFO_EN,
    output logic      [15:0]         DIVISOR,
    output logic      [7:0]          LINE_CTRL,
    output logic      [7:0]          EFR_OUT,
    output logic                     SLEEP_EN,
    output logic                     IRQ
);
    logic [2:0]  a_ofs_reg;
    logic        a_wr_reg;
    logic        a_rd_reg;
    logic [7:0]  ie_reg;
    logic [7:0]  lcr_reg;
    logic [7:0]  efr_reg;
    logic [15:0] div_reg;
    logic        fen_reg;
    logic [1:0]  rxtrig_reg;
    logic [1:0]  txtrig_reg;
    logic        rxrst_reg;
    logic        txrst_reg;
    logic        dr_reg;
    logic        ovr_reg;
    logic [2:0]  err_reg;
    logic        ls_irq_reg;
    logic        tx_irq_reg;
    logic        to_irq_reg;
    logic        xoff_irq_reg;
    logic        spc_irq_reg;
    logic        flow_irq_reg;
    logic        wake_irq_reg;
    logic        cts_d_reg;
    logic        rts_d_reg;
    logic        tx_low_d_reg;
    logic [23:0] to_cnt_reg;
    logic [5:0]  code_reg;
    logic [5:0]  code_next;
    logic [7:0]  rdata_next;
    logic [31:0] HRDATA_reg;
    logic        enh;
    logic        w_any;
    logic        wr;
    logic        rd;
    logic        rx_trig_hit;
    logic        tx_low;
    logic        rx_irq;
    logic        msr_irq;
    logic [23:0] to_limit;

    function automatic logic [LW-1:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_level = LW'(1);
            2'h1: trig_level = LW'(4);
            2'h2: trig_level = LW'(8);
            2'h3: trig_level = LW'(14);
        endcase
    endfunction

    assign enh       = efr_reg[uic_pkg::EFR_ENH];
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = HRDATA_reg;
    assign w_any     = HSEL && HREADY && HTRANS[1];
    assign wr        = a_wr_reg && CE;
    assign rd        = a_rd_reg && CE;

    // address phase capture; registers at byte offset 4*index
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            a_ofs_reg <= 3'h0;
            a_wr_reg  <= 1'b0;
            a_rd_reg  <= 1'b0;
        end else if (CE) begin
            a_ofs_reg <= HADDR[4:2];
            a_wr_reg  <= w_any && HWRITE;
            a_rd_reg  <= w_any && !HWRITE;
        end
    end

    // offset 0x20 reserved for the enhanced register image at offset 2
    logic a_efr_reg;
    logic efr_hit;
    assign efr_hit = HADDR[5] || (lcr_reg == uic_pkg::LCR_ENH && HADDR[4:2] == 3'h2);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            a_efr_reg <= 1'b0;
        end else if (CE) begin
            a_efr_reg <= efr_hit;
        end
    end

    logic dlab;
    assign dlab = lcr_reg[uic_pkg::LCR_DLAB];

    // control register writes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ie_reg     <= uic_pkg::IE_RST;
            lcr_reg    <= uic_pkg::LCR_RST;
            efr_reg    <= 8'h00;
            div_reg    <= 16'h0000;
            fen_reg    <= 1'b0;
            rxtrig_reg <= 2'h0;
            txtrig_reg <= 2'h0;
            rxrst_reg  <= 1'b0;
            txrst_reg  <= 1'b0;
        end else if (CE) begin
            rxrst_reg <= 1'b0; // R21
            txrst_reg <= 1'b0; // R24
            if (a_wr_reg) begin
                if (a_efr_reg) begin
                    efr_reg <= HWDATA[7:0];
                end else if (a_ofs_reg == uic_pkg::OFS_LCR) begin
                    lcr_reg <= HWDATA[7:0];
                end else if (dlab && a_ofs_reg == uic_pkg::OFS_DATA) begin
                    div_reg[7:0] <= HWDATA[7:0]; // R22
                end else if (dlab && a_ofs_reg == uic_pkg::OFS_IE) begin
                    div_reg[15:8] <= HWDATA[7:0]; // R22
                end else if (a_ofs_reg == uic_pkg::OFS_IE) begin
                    ie_reg[3:0] <= HWDATA[3:0]; // R26
                    if (enh) begin
                        ie_reg[7:4] <= HWDATA[7:4]; // R5
                    end
                end else if (a_ofs_reg == uic_pkg::OFS_ISFC) begin
                    fen_reg <= HWDATA[uic_pkg::FC_EN]; // R20
                    if (HWDATA[uic_pkg::FC_EN]) begin
                        rxrst_reg  <= HWDATA[uic_pkg::FC_RXRST]; // R21
                        txrst_reg  <= HWDATA[uic_pkg::FC_TXRST]; // R24
                        rxtrig_reg <= HWDATA[7:6]; // R23
                        if (enh) begin
                            txtrig_reg <= HWDATA[5:4]; // R23
                        end
                    end
                end
            end
        end
    end

    logic hold_rd;
    logic hold_wr;
    logic isr_rd;
    logic lsr_rd;
    logic msr_rd;
    assign hold_rd = rd && !a_efr_reg && !dlab && a_ofs_reg == uic_pkg::OFS_DATA;
    assign hold_wr = wr && !a_efr_reg && !dlab && a_ofs_reg == uic_pkg::OFS_DATA;
    assign isr_rd  = rd && !a_efr_reg && a_ofs_reg == uic_pkg::OFS_ISFC;
    assign lsr_rd  = rd && !a_efr_reg && a_ofs_reg == uic_pkg::OFS_LSR;
    assign msr_rd  = rd && !a_efr_reg && a_ofs_reg == uic_pkg::OFS_MSR;

    assign rx_trig_hit = fen_reg ? (RX_LEVEL >= trig_level(rxtrig_reg)) // R7
                                 : dr_reg; // R1
    assign tx_low  = fen_reg ? (TX_LEVEL < trig_level(txtrig_reg))
                             : CORE.tx_empty_hold; // R2
    assign rx_irq  = ie_reg[0] && rx_trig_hit; // R1
    assign msr_irq = ie_reg[3] && (|CORE.modem_delta); // R4
    // character time approximated as ten bits of sixteen baud ticks each
    assign to_limit = 24'((uic_pkg::TO_CHARS * 10 + uic_pkg::TO_BITS) * uic_pkg::BAUD_OVS)
                      * 24'(div_reg == 16'h0000 ? 16'h0001 : div_reg);

    // line status bits; set wins over clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dr_reg     <= 1'b0;
            ovr_reg    <= 1'b0;
            err_reg    <= 3'h0;
            ls_irq_reg <= 1'b0;
        end else if (CE) begin
            if (CORE.rx_push) begin
                dr_reg <= 1'b1; // R8
            end else if (RX_LEVEL == LW'(0)) begin
                dr_reg <= 1'b0; // R8
            end
            if (CORE.rx_overrun) begin
                ovr_reg <= 1'b1; // R3
            end else if (lsr_rd) begin
                ovr_reg <= 1'b0;
            end
            if (CORE.rx_pop_err) begin
                err_reg <= CORE.rx_err_type; // R3
            end else if (lsr_rd) begin
                err_reg <= 3'h0;
            end
            if (CORE.rx_overrun || (CORE.rx_pop_err && |CORE.rx_err_type)) begin
                ls_irq_reg <= 1'b1; // R3
            end else if (lsr_rd) begin
                ls_irq_reg <= 1'b0; // R12
            end
        end
    end

    // transmit ready, timeout, flow and misc interrupt sources
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_irq_reg   <= 1'b0;
            to_irq_reg   <= 1'b0;
            to_cnt_reg   <= 24'h000000;
            xoff_irq_reg <= 1'b0;
            spc_irq_reg  <= 1'b0;
            flow_irq_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
            cts_d_reg    <= 1'b0;
            rts_d_reg    <= 1'b0;
            tx_low_d_reg <= 1'b0;
        end else if (CE) begin
            cts_d_reg    <= CORE.cts_pin;
            rts_d_reg    <= CORE.rts_pin;
            tx_low_d_reg <= tx_low && ie_reg[1];
            if (tx_low && ie_reg[1] && !tx_low_d_reg) begin
                tx_irq_reg <= 1'b1; // R2
            end else if (isr_rd || hold_wr || !ie_reg[1]) begin
                tx_irq_reg <= 1'b0; // R11
            end
            if (CORE.rx_push || hold_rd || RX_LEVEL == LW'(0)) begin
                to_cnt_reg <= 24'h000000;
            end else if (to_cnt_reg != to_limit) begin
                to_cnt_reg <= to_cnt_reg + 24'h000001;
            end
            if (ie_reg[0] && fen_reg && to_cnt_reg == to_limit - 24'h000001) begin
                to_irq_reg <= 1'b1; // R10
            end else if (hold_rd) begin
                to_irq_reg <= 1'b0; // R10
            end
            if (CORE.xoff_det && ie_reg[5]) begin
                xoff_irq_reg <= 1'b1;
            end else if (isr_rd || CORE.xon_det) begin
                xoff_irq_reg <= 1'b0; // R14
            end
            if (CORE.special_det && ie_reg[5]) begin
                spc_irq_reg <= 1'b1;
            end else if (isr_rd || CORE.rx_push) begin
                spc_irq_reg <= 1'b0; // R14
            end
            if ((ie_reg[7] && efr_reg[uic_pkg::EFR_ACTS] && CORE.cts_pin && !cts_d_reg) ||
                (ie_reg[6] && efr_reg[uic_pkg::EFR_ARTS] && CORE.rts_pin && !rts_d_reg)) begin
                flow_irq_reg <= 1'b1; // R6
            end else if (msr_rd) begin
                flow_irq_reg <= 1'b0; // R13
            end
            if (CORE.wake) begin
                wake_irq_reg <= 1'b1; // R15
            end else if (isr_rd) begin
                wake_irq_reg <= 1'b0; // R15
            end
        end
    end

    // priority encode; code is re-registered on every enabled clock, status reads included
    always_comb begin
        code_next = uic_pkg::CODE_NONE; // R18
        if (ie_reg[2] && ls_irq_reg) begin
            code_next = uic_pkg::CODE_LS; // R16
        end else if (to_irq_reg) begin
            code_next = uic_pkg::CODE_TO;
        end else if (rx_irq) begin
            code_next = uic_pkg::CODE_RX; // R7
        end else if (tx_irq_reg) begin
            code_next = uic_pkg::CODE_TX;
        end else if (msr_irq) begin
            code_next = uic_pkg::CODE_MS;
        end else if (enh && (xoff_irq_reg || spc_irq_reg)) begin
            code_next = uic_pkg::CODE_XOFF; // R19
        end else if (enh && flow_irq_reg) begin
            code_next = uic_pkg::CODE_FLOW; // R19
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            code_reg <= uic_pkg::CODE_NONE;
        end else if (CE) begin
            code_reg <= code_next; // R17
        end
    end

    // read mux on the address phase; a read right behind an lcr write sees the old select
    always_comb begin
        rdata_next = 8'h00;
        if (efr_hit) begin
            rdata_next = efr_reg;
        end else begin
            unique case (HADDR[4:2])
                3'h0:    rdata_next = dlab ? div_reg[7:0] : RX_DATA;
                3'h1:    rdata_next = dlab ? div_reg[15:8] : ie_reg;
                3'h2:    rdata_next = {fen_reg, fen_reg, code_reg}; // R19
                3'h3:    rdata_next = lcr_reg;
                3'h5:    rdata_next = {CORE.rx_fifo_err, CORE.tx_all_empty, // R9
                                       CORE.tx_empty_hold, err_reg, ovr_reg, dr_reg};
                3'h6:    rdata_next = {CORE.modem_in, CORE.modem_delta};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA_reg <= 32'h00000000;
        end else if (CE && w_any && !HWRITE) begin
            // captured with the address so it stands through the data phase
            HRDATA_reg <= {24'h000000, rdata_next};
        end
    end

    assign RX_POP      = hold_rd;
    assign TX_PUSH     = hold_wr;
    assign TX_DATA     = HWDATA[7:0];
    assign RX_FIFO_RST = rxrst_reg;
    assign TX_FIFO_RST = txrst_reg;
    assign FIFO_EN     = fen_reg;
    assign DIVISOR     = div_reg;
    assign LINE_CTRL   = lcr_reg;
    assign EFR_OUT     = efr_reg;
    assign SLEEP_EN    = ie_reg[4];
    assign IRQ         = (code_reg != uic_pkg::CODE_NONE); // R25

    a_upper_ie_lock: assert property (@(posedge CLK) disable iff (!RST_N) // R5
        (!enh && !a_efr_reg) |=> ie_reg[7:4] == $past(ie_reg[7:4]) || $past(enh))
        else $error("upper enables changed without enhanced bit");
    a_rst_self_clear: assert property (@(posedge CLK) disable iff (!RST_N) // R21
        CE && rxrst_reg |=> !rxrst_reg)
        else $error("rx fifo reset did not self clear");
    a_irq_code: assert property (@(posedge CLK) disable iff (!RST_N) // R18
        IRQ == !code_reg[0])
        else $error("irq and status bit 0 disagree");
    a_ls_first: assert property (@(posedge CLK) disable iff (!RST_N) // R16
        CE && ie_reg[2] && ls_irq_reg |=> code_reg == uic_pkg::CODE_LS)
        else $error("line status not highest priority");
    a_tx_clear: assert property (@(posedge CLK) disable iff (!RST_N) // R11
        CE && hold_wr && !(tx_low && ie_reg[1] && !tx_low_d_reg) |=> !tx_irq_reg)
        else $error("transmit ready not cleared");
    a_flow_clear: assert property (@(posedge CLK) disable iff (!RST_N) // R13
        msr_rd && !CORE.cts_pin && !CORE.rts_pin |=> !flow_irq_reg)
        else $error("flow irq not cleared by modem read");
    a_fen_gate: assert property (@(posedge CLK) disable iff (!RST_N) // R20
        CE && a_wr_reg && !a_efr_reg && a_ofs_reg == uic_pkg::OFS_ISFC && !HWDATA[0]
        |=> !rxrst_reg && !txrst_reg && $stable(rxtrig_reg))
        else $error("fifo control bits taken without enable");
    a_dr_hold: assert property (@(posedge CLK) disable iff (!RST_N) // R8
        CE && CORE.rx_push |=> dr_reg)
        else $error("data ready not set on push");
    c_ls_irq: cover property (@(posedge CLK) code_reg == uic_pkg::CODE_LS);
    c_timeout: cover property (@(posedge CLK) code_reg == uic_pkg::CODE_TO);
    c_flow: cover property (@(posedge CLK) code_reg == uic_pkg::CODE_FLOW);
endmodule

// file: verif/uic_core_model.sv
// behavioural uart core standing behind the control block: fifo levels and tx drain
`timescale 1ns/1ps
module uic_core_model #(
    parameter int LW = 5
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // bench requests
    input  wire logic               push_req,
    input  wire uic_pkg::uic_core_s core_in,
    // control from the block
    input  wire logic               rx_pop,
    input  wire logic               tx_push,
    input  wire logic               rx_rst,
    input  wire logic               tx_rst,
    // status to the block
    output uic_pkg::uic_core_s      core_out,
    output logic [LW-1:0]           rx_level,
    output logic [LW-1:0]           tx_level,
    output logic [7:0]              rx_data
);
    // a pop on an empty fifo is ignored, as the real pointers would wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_level <= '0;
            tx_level <= '0;
            rx_data  <= 8'h00;
        end else begin
            if (rx_rst) begin
                rx_level <= '0;
            end else begin
                rx_level <= rx_level + LW'(push_req) - LW'(rx_pop && rx_level != '0);
            end
            if (rx_pop) begin
                rx_data <= rx_data + 8'h01;
            end
            // the shifter drains one character a cycle, far faster than a line
            if (tx_rst) begin
                tx_level <= '0;
            end else if (tx_push) begin
                tx_level <= tx_level + LW'(1);
            end else if (tx_level != '0) begin
                tx_level <= tx_level - LW'(1);
            end
        end
    end

    always_comb begin
        core_out               = core_in;
        core_out.rx_push       = push_req;
        core_out.tx_empty_hold = (tx_level == '0);
        core_out.tx_all_empty  = (tx_level == '0);
    end
endmodule

// file: verif/uart_interrupt_fifo_control_test.sv
// self-checking bench for the interrupt and fifo control block
`timescale 1ns/1ps
module uart_interrupt_fifo_control_test;
    localparam int         LW   = 5;
    localparam logic [3:0] A_DT = {1'b0, uic_pkg::OFS_DATA};
    localparam logic [3:0] A_IE = {1'b0, uic_pkg::OFS_IE};
    localparam logic [3:0] A_IS = {1'b0, uic_pkg::OFS_ISFC};
    localparam logic [3:0] A_LC = {1'b0, uic_pkg::OFS_LCR};
    localparam logic [3:0] A_LS = {1'b0, uic_pkg::OFS_LSR};
    localparam logic [3:0] A_MS = {1'b0, uic_pkg::OFS_MSR};
    logic               clk      = 1'b0;
    logic               rst_n    = 1'b0;
    logic [31:0]        haddr    = '0;
    logic [1:0]         htrans   = '0;
    logic               hwrite   = 1'b0;
    logic [31:0]        hwdata   = '0;
    logic               push_req = 1'b0;
    logic               ce       = 1'b1;
    logic               txr_q    = 1'b0;
    uic_pkg::uic_core_s core_r   = '0;
    uic_pkg::uic_core_s core_m;
    logic [31:0]        hrdata, rd_q, v;
    logic               hreadyout, rx_pop, tx_push, rx_rst, tx_rst, irq;
    logic [LW-1:0]      rx_level, tx_level;
    logic [7:0]         rx_data;
    logic [15:0]        divisor;
    int                 err_count   = 0;
    int                 check_count = 0;

    uic_top #(.DEPTH(16), .LW(LW)) dut (
        .CLK(clk), .RST_N(rst_n), .CE(ce),
        .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(), .CORE(core_m), .RX_LEVEL(rx_level), .TX_LEVEL(tx_level),
        .RX_DATA(rx_data), .RX_POP(rx_pop), .TX_PUSH(tx_push), .TX_DATA(),
        .RX_FIFO_RST(rx_rst), .TX_FIFO_RST(tx_rst), .FIFO_EN(), .DIVISOR(divisor),
        .LINE_CTRL(), .EFR_OUT(), .SLEEP_EN(), .IRQ(irq));

    uic_core_model #(.LW(LW)) core (
        .clk(clk), .rst_n(rst_n), .push_req(push_req), .core_in(core_r),
        .rx_pop(rx_pop), .tx_push(tx_push), .rx_rst(rx_rst), .tx_rst(tx_rst),
        .core_out(core_m), .rx_level(rx_level), .tx_level(tx_level), .rx_data(rx_data));

    always #12.5 clk = ~clk;
    // read data as it stood just before the closing edge of the data phase
    always @(posedge clk) rd_q <= hrdata;
    // sticky record of any transmit fifo reset pulse
    always @(posedge clk) txr_q <= txr_q | tx_rst;

    task automatic complete_run();
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] ofs, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        htrans <= 2'h2;
        haddr  <= {26'h0, ofs, 2'b00};
        hwrite <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        #1 v = rd_q;
        if (n >= 100) begin
            err_count++;
            complete_run();
        end
    endtask

    task automatic rdc(input logic [3:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, '0);
        chk(v, exp);
    endtask

    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        bus(1'b1, ofs, {24'h0, d});
    endtask

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            push_req <= 1'b1;
        end
        @(posedge clk);
        push_req <= 1'b0;
    endtask

    task automatic evt(input uic_pkg::uic_core_s m);
        @(posedge clk);
        core_r <= core_r | m;
        @(posedge clk);
        core_r <= core_r & ~m;
    endtask

    function automatic int trig(input logic [1:0] c);
        return c == 2'd0 ? 1 : c == 2'd1 ? 4 : c == 2'd2 ? 8 : 14;
    endfunction

    // receive timeout in clocks, a character counted as ten bits
    function automatic int to_cycles(input logic [7:0] d);
        return (uic_pkg::TO_CHARS * 10 + uic_pkg::TO_BITS) * uic_pkg::BAUD_OVS * int'(d);
    endfunction

    initial begin
        #2000000;
        err_count++;
        complete_run();
    end

    initial begin
        int t, n;
        logic [1:0] c;
        logic [7:0] dl;
        uic_pkg::uic_core_s m;
        void'($urandom(32'hb3670a47));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(A_IS, 32'h01);
        wr(A_IE, 8'hf0);
        rdc(A_IE, 32'h00);
        rdc(4'hf, 32'h00);
        wr(A_IS, 8'h01);
        rdc(A_IS, 32'hc1);
        wr(A_IS, 8'hc6);
        rdc(A_IS, 32'h01);
        chk({31'h0, txr_q}, 32'h0);
        // small divisor keeps the receive timeout within the run
        dl = 8'h10 + 8'($urandom_range(15));
        wr(A_LC, 8'h80);
        wr(A_DT, dl);
        wr(A_IE, 8'h00);
        wr(A_LC, 8'h03);
        chk({16'h0, divisor}, {24'h0, dl});
        wr(A_DT, 8'($urandom));
        chk({16'h0, divisor}, {24'h0, dl});
        t = $urandom_range(3);
        for (int i = 0; i < 4; i++) begin
            c = 2'(t + i);
            wr(A_IS, {c, 6'h03});
            wr(A_IE, 8'h01);
            push(trig(c) - 1);
            rdc(A_IS, 32'hc1);
            push(1);
            rdc(A_IS, 32'hc4);
            chk({31'h0, irq}, 32'h1);
            bus(1'b0, A_DT, '0);
            rdc(A_IS, 32'hc1);
            wr(A_IE, 8'h00);
        end
        push(3);
        wr(A_IS, 8'h07);
        // data ready drops one clock after the level reads zero
        @(posedge clk);
        rdc(A_LS, 32'h60);
        chk({27'h0, rx_level}, 32'h0);
        chk({31'h0, txr_q}, 32'h1);
        wr(A_IE, 8'h05);
        push(1);
        m = '0;
        m.rx_overrun = 1'b1;
        evt(m);
        rdc(A_IS, 32'hc6);
        rdc(A_LS, 32'h63);
        rdc(A_IS, 32'hc4);
        bus(1'b0, A_DT, '0);
        m = '0;
        m.rx_pop_err = 1'b1;
        m.rx_err_type = 3'h2;
        evt(m);
        rdc(A_IS, 32'hc6);
        rdc(A_LS, 32'h68);
        @(posedge clk);
        core_r.rx_fifo_err <= 1'b1;
        rdc(A_LS, 32'he0);
        rdc(A_IS, 32'hc1);
        wr(A_IE, 8'h02);
        @(posedge clk);
        rdc(A_IS, 32'hc2);
        rdc(A_IS, 32'hc1);
        wr(A_IE, 8'h08);
        @(posedge clk);
        core_r.modem_delta <= 4'h4;
        rdc(A_IS, 32'hc0);
        @(posedge clk);
        core_r.modem_delta <= 4'h0;
        bus(1'b0, A_MS, '0);
        rdc(A_IS, 32'hc1);
        chk({31'h0, irq}, 32'h0);
        // a low clock enable must hold the code while a modem delta arrives
        @(posedge clk);
        ce <= 1'b0;
        core_r.modem_delta <= 4'h1;
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        core_r.modem_delta <= 4'h0;
        wr(A_LC, 8'hbf);
        wr(A_IS, 8'h90);
        wr(A_LC, 8'h03);
        wr(A_IE, 8'h80);
        rdc(A_IE, 32'h80);
        @(posedge clk);
        core_r.cts_pin <= 1'b1;
        @(posedge clk);
        rdc(A_IS, 32'he0);
        bus(1'b0, A_MS, '0);
        rdc(A_IS, 32'hc1);
        wr(A_IS, 8'hc3);
        wr(A_IE, 8'h01);
        push(1);
        n = 0;
        while (irq !== 1'b1 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        chk(32'(n >= to_cycles(dl) && n <= to_cycles(dl) + 4), 32'h1);
        rdc(A_IS, 32'hcc);
        bus(1'b0, A_DT, '0);
        rdc(A_IS, 32'hc1);
        complete_run();
    end
endmodule
